// ### fes_seq.sv
/*
   Flash erase and unsecure sequencer: loads command words, checks them at
   launch, runs full, block and sector erase with verify, unsecure and
   backdoor key verification, and keeps security and the key lockout.
   Assumes the array, protection and key read ports are on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fes_regs.svh"
// Overview of operation
// R1 - Code 08 erases and verifies everything; index other than 000 gives access error.
// R2 - A clean verify after code 08 releases security.
// R3 - Software must not write flash registers while these commands run.
// R4 - Completion flag stays low until the whole command, verify included, ends.
// R5 - Full erase and unsecure flag protection violation if any area is protected.
// R6 - Verify errors set the verify flag; uncorrectable ones set the second flag.
// R7 - Code 09 erases one block from bits 22:16 and 15:0; index 001.
// R8 - Block erase: bad block, misaligned store address give access error.
// R9 - Block erase flags protection violation if the block is protected.
// R10 - Code 0A erases the sector holding the address; index 001.
// R11 - Sector erase: address bits 2:0 not zero or bad block give access error.
// R12 - Sector erase flags protection violation if the sector is protected.
// R13 - Code 0B erases both arrays, index 000, unsecures on clean verify.
// R14 - Failed unsecure verify sets verify flag and keeps security.
// R15 - Code 0C takes four keys; index other than 100 gives access error.
// R16 - Key enable field other than 10 gives access error and ends.
// R17 - Keys compare in order from 0x7F_FF00; all matching releases security.
// R18 - A mismatch keeps security and locks key checks out until reset.
// R19 - Software must not run key checks from the key's own block.
// R20 - A launch error skips all work and sets the completion flag again.
module fes_seq
   import fes_pkg::*;
#(
   parameter logic [6:0] PF_LO = `FES_PF_BLK_LO,
   parameter logic [6:0] PF_HI = `FES_PF_BLK_HI,
   parameter logic [6:0] DF_BLK = `FES_DF_BLK
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Command word loading.
   input wire logic cmd_wr_i,
   input wire logic [2:0] command_word_index_i,
   input wire logic [15:0] command_parameter_words_i,
   // Launch and status.
   input wire logic launch_i,
   input wire logic [3:0] flag_clr_i,
   output logic command_complete_flag_o,
   output logic access_error_flag_o,
   output logic protection_violation_flag_o,
   output logic verify_error_flag_o,
   output logic verify_uncorrectable_flag_o,
   // Security.
   input wire logic [1:0] backdoor_key_enable_field_i,
   input wire logic secured_strap_i,
   output logic secured_o,
   output logic key_locked_o,
   // Protection lookup.
   input wire logic pflash_prot_any_i,
   input wire logic dflash_prot_any_i,
   input wire logic target_prot_i,
   // Erase and verify engine.
   output logic erase_req_o,
   output fes_op_t erase_op_o,
   output logic [22:0] erase_addr_o,
   input wire logic erase_done_i,
   input wire logic verify_err_i,
   input wire logic verify_uncorr_i,
   // Stored key read.
   output logic key_rd_req_o,
   output logic [22:0] key_rd_addr_o,
   input wire logic key_rd_valid_i,
   input wire logic [15:0] key_rd_data_i
);
   // ========================================================================
   // Declarations.
   fes_seq_st_t s_q;
   fes_seq_st_t s_d;
   logic acc_w;
   logic last_w;
   logic bad_w;
   logic [7:0] cmd_w;
   fes_blk_t kind_w;
   fes_mem_if #(.W(16), .AW(3)) mif ();
   fes_flag_if #(.N(4)) fif ();

   // Classify a block code as program store, data store or invalid.
   function automatic fes_blk_t blk_kind(input logic [6:0] blk);
      if (blk >= PF_LO && blk <= PF_HI) begin
         blk_kind = BLK_PF;
      end else if (blk == DF_BLK) begin
         blk_kind = BLK_DF;
      end else begin
         blk_kind = BLK_NONE;
      end
   endfunction

   // ========================================================================
   // Submodules.
   fes_cmd_mem #(.W(16), .AW(3)) u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .m(mif)
   );
   fes_flags #(.N(4)) u_flags (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .f(fif)
   );

   // Software writes reach the store only while no command is running.
   assign mif.wr = cmd_wr_i & s_q.command_complete_flag; // [R3]
   assign mif.waddr = command_word_index_i;
   assign mif.wdata = command_parameter_words_i;
   assign fif.clr = flag_clr_i;

   // Decoded fields of the captured words.
   assign cmd_w = s_q.w0[`FES_CMD_MSB:`FES_CMD_LSB];
   assign kind_w = blk_kind(s_q.w0[`FES_BLK_MSB:0]);
   assign last_w = (s_q.kk == `FES_KEY_LAST);
   assign bad_w = s_q.kbad | (mif.rdata != key_rd_data_i);

   // ========================================================================
   // Sequencer next state.
   always_comb begin
      s_d = s_q;
      s_d.req = 1'b0;
      acc_w = 1'b0;
      fif.set = '0;
      mif.raddr = `FES_IDX_W0;
      if (!s_q.init) begin
         s_d.init = 1'b1;
         s_d.sec = secured_strap_i;
      end
      case (s_q.st)
         ST_IDLE: begin
            if (launch_i && s_q.command_complete_flag) begin
               s_d.command_complete_flag = 1'b0; // [R4]
               s_d.idx = command_word_index_i;
               s_d.st = ST_W0;
            end
         end
         ST_W0: begin
            s_d.w0 = mif.rdata;
            mif.raddr = `FES_IDX_W1;
            s_d.st = ST_W1;
         end
         ST_W1: begin
            s_d.w1 = mif.rdata;
            s_d.st = ST_CHECK;
         end
         ST_CHECK: begin
            case (cmd_w)
               `FES_CMD_ERASE_ALL, `FES_CMD_UNSECURE: begin
                  acc_w = (s_q.idx != `FES_IDX_W0); // [R1] [R13]
                  s_d.op = OP_ALL;
               end
               `FES_CMD_ERASE_BLK: begin
                  acc_w = (s_q.idx != `FES_IDX_W1) || (kind_w == BLK_NONE) || // [R7] [R8]
                          (kind_w == BLK_PF && (s_q.w1 & `FES_PHRASE_MASK) != 16'h0000) ||
                          (kind_w == BLK_DF && (s_q.w1 & `FES_WORD_MASK) != 16'h0000);
                  s_d.op = OP_BLOCK;
               end
               `FES_CMD_ERASE_SEC: begin
                  acc_w = (s_q.idx != `FES_IDX_W1) || (kind_w != BLK_PF) || // [R10] [R11]
                          ((s_q.w1 & `FES_PHRASE_MASK) != 16'h0000);
                  s_d.op = OP_SECTOR;
               end
               `FES_CMD_KEY: begin
                  acc_w = (s_q.idx != `FES_IDX_KEY3) || // [R15]
                          (backdoor_key_enable_field_i != `FES_BACKDOOR_KEY_ENABLE_FIELD_ON) || // [R16]
                          s_q.lock; // [R18]
               end
               default: begin
                  acc_w = 1'b1;
               end
            endcase
            s_d.addr = {s_q.w0[`FES_BLK_MSB:0], s_q.w1};
            s_d.kk = 2'h0;
            s_d.kbad = 1'b0;
            if (acc_w) begin
               fif.set[`FES_F_ACC] = 1'b1;
               s_d.st = ST_DONE; // [R20]
            end else if (cmd_w == `FES_CMD_KEY) begin
               s_d.addr = `FES_KEY_BASE; // [R17]
               s_d.st = ST_KEY;
            end else begin
               s_d.st = ST_PROT;
            end
         end
         ST_PROT: begin
            if (s_q.op == OP_ALL ? (pflash_prot_any_i | dflash_prot_any_i) // [R5]
                                 : target_prot_i) begin // [R9] [R12]
               fif.set[`FES_F_FPV] = 1'b1;
               s_d.st = ST_DONE; // [R20]
            end else begin
               s_d.req = 1'b1;
               s_d.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (erase_done_i) begin
               fif.set[`FES_F_MG1] = verify_err_i | verify_uncorr_i; // [R6] [R14]
               fif.set[`FES_F_MG0] = verify_uncorr_i; // [R6]
               if (s_q.op == OP_ALL && !verify_err_i && !verify_uncorr_i) begin
                  s_d.sec = 1'b0; // [R2] [R13]
               end
               s_d.st = ST_DONE;
            end
         end
         ST_KEY: begin
            mif.raddr = 3'(`FES_IDX_W1 + s_q.kk);
            s_d.st = ST_KWAIT;
         end
         ST_KWAIT: begin
            mif.raddr = 3'(`FES_IDX_W1 + s_q.kk);
            if (key_rd_valid_i) begin
               s_d.kbad = bad_w; // [R17]
               s_d.kk = 2'(s_q.kk + 2'h1);
               s_d.addr = 23'(s_q.addr + `FES_KEY_STEP);
               s_d.st = ST_KEY;
               if (last_w) begin
                  if (bad_w) begin
                     s_d.lock = 1'b1; // [R18]
                     fif.set[`FES_F_ACC] = 1'b1;
                  end else begin
                     s_d.sec = 1'b0; // [R17]
                  end
                  s_d.st = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            s_d.command_complete_flag = 1'b1; // [R4]
            s_d.st = ST_IDLE;
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   // Register the sequencer; reset also clears the key lockout.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.command_complete_flag <= `FES_COMMAND_COMPLETE_FLAG_RST;
         s_q.sec <= `FES_SEC_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ========================================================================
   // Outputs.
   assign command_complete_flag_o = s_q.command_complete_flag;
   assign access_error_flag_o = fif.q[`FES_F_ACC];
   assign protection_violation_flag_o = fif.q[`FES_F_FPV];
   assign verify_error_flag_o = fif.q[`FES_F_MG1];
   assign verify_uncorrectable_flag_o = fif.q[`FES_F_MG0];
   assign secured_o = s_q.sec;
   assign key_locked_o = s_q.lock;
   assign erase_req_o = s_q.req;
   assign erase_op_o = s_q.op;
   assign erase_addr_o = s_q.addr;
   assign key_rd_req_o = (s_q.st == ST_KWAIT);
   assign key_rd_addr_o = s_q.addr;

   // ========================================================================
   // Assertions.
   sequence s_launch;
      s_q.st == ST_IDLE && launch_i && s_q.command_complete_flag;
   endsequence
   sequence s_fetch;
      s_q.st == ST_W0 ##1 s_q.st == ST_W1 ##1 s_q.st == ST_CHECK;
   endsequence
   sequence s_finish;
      s_q.st == ST_DONE && !command_complete_flag_o ##1 command_complete_flag_o;
   endsequence

   property p_busy;
      @(posedge clk_i) disable iff (rst_i)
      s_launch |=> (s_fetch and (!command_complete_flag_o [*3]));
   endproperty
   a_busy: assert property (p_busy) else $error("flag not low while busy"); // [R4]

   property p_idx_all;
      @(posedge clk_i) disable iff (rst_i)
      s_q.st == ST_CHECK && (cmd_w == `FES_CMD_ERASE_ALL || cmd_w == `FES_CMD_UNSECURE)
         && s_q.idx != `FES_IDX_W0 |=> access_error_flag_o ##0 s_finish;
   endproperty
   a_idx_all: assert property (p_idx_all) else $error("bad index not refused"); // [R1]

   property p_release;
      @(posedge clk_i) disable iff (rst_i)
      s_q.st == ST_WAIT && erase_done_i && s_q.op == OP_ALL && !verify_err_i
         && !verify_uncorr_i |=> !secured_o ##0 s_finish;
   endproperty
   a_release: assert property (p_release) else $error("security not released"); // [R2]

   property p_unsec_fail;
      @(posedge clk_i) disable iff (rst_i)
      s_q.st == ST_WAIT && erase_done_i && cmd_w == `FES_CMD_UNSECURE && verify_err_i
         |=> $stable(secured_o) && verify_error_flag_o;
   endproperty
   a_unsec_fail: assert property (p_unsec_fail) else $error("failed unsecure changed state"); // [R14]

   property p_prot_all;
      @(posedge clk_i) disable iff (rst_i)
      s_q.st == ST_PROT && s_q.op == OP_ALL && (pflash_prot_any_i || dflash_prot_any_i)
         |=> protection_violation_flag_o && !erase_req_o;
   endproperty
   a_prot_all: assert property (p_prot_all) else $error("protection not flagged"); // [R5]

   property p_prot_tgt;
      @(posedge clk_i) disable iff (rst_i)
      s_q.st == ST_PROT && s_q.op != OP_ALL && target_prot_i
         |=> protection_violation_flag_o ##0 s_finish;
   endproperty
   a_prot_tgt: assert property (p_prot_tgt) else $error("target protection missed"); // [R9] [R12]

   property p_uncorr;
      @(posedge clk_i) disable iff (rst_i)
      s_q.st == ST_WAIT && erase_done_i && verify_uncorr_i
         |=> verify_uncorrectable_flag_o && verify_error_flag_o;
   endproperty
   a_uncorr: assert property (p_uncorr) else $error("verify flags not set"); // [R6]

   property p_erase_addr;
      @(posedge clk_i) disable iff (rst_i)
      s_q.st == ST_PROT && s_q.op != OP_ALL && !target_prot_i
         |=> erase_req_o && erase_addr_o == {s_q.w0[`FES_BLK_MSB:0], s_q.w1};
   endproperty
   a_erase_addr: assert property (p_erase_addr) else $error("wrong erase address"); // [R7] [R10]

   property p_sec_align;
      @(posedge clk_i) disable iff (rst_i)
      s_q.st == ST_CHECK && cmd_w == `FES_CMD_ERASE_SEC && s_q.w1[2:0] != 3'h0
         |=> access_error_flag_o && s_q.st == ST_DONE;
   endproperty
   a_sec_align: assert property (p_sec_align) else $error("misaligned sector taken"); // [R11]

   property p_backdoor_key_enable_field;
      @(posedge clk_i) disable iff (rst_i)
      s_q.st == ST_CHECK && cmd_w == `FES_CMD_KEY && backdoor_key_enable_field_i != `FES_BACKDOOR_KEY_ENABLE_FIELD_ON
         |=> access_error_flag_o ##0 s_finish;
   endproperty
   a_backdoor_key_enable_field: assert property (p_backdoor_key_enable_field) else $error("disabled key command ran"); // [R16]

   property p_lock;
      @(posedge clk_i) disable iff (rst_i)
      key_locked_o |=> key_locked_o && !(s_q.st == ST_KEY);
   endproperty
   a_lock: assert property (p_lock) else $error("key lockout lost"); // [R18]

   property p_skip;
      @(posedge clk_i) disable iff (rst_i)
      s_q.st == ST_CHECK && acc_w |=> !erase_req_o && !key_rd_req_o && $stable(secured_o)
         ##1 command_complete_flag_o;
   endproperty
   a_skip: assert property (p_skip) else $error("refused command did work"); // [R20]
endmodule // fes_seq
`default_nettype wire

// ### fes_regs.svh
/*
   Constants of the flash erase and unsecure sequencer: command codes, word
   indices, field positions, flag positions and reset values.
   Assumes it is included by its bare name after the package.
*/
`ifndef FES_REGS_SVH
`define FES_REGS_SVH
// ==========================================================================
// Command codes carried in the upper byte of word 0.
`define FES_CMD_ERASE_ALL 8'h08
`define FES_CMD_ERASE_BLK 8'h09
`define FES_CMD_ERASE_SEC 8'h0A
`define FES_CMD_UNSECURE 8'h0B
`define FES_CMD_KEY 8'h0C
// ==========================================================================
// Final word index that each command must show at launch.
`define FES_IDX_W0 3'h0
`define FES_IDX_W1 3'h1
`define FES_IDX_KEY3 3'h4
// ==========================================================================
// Field positions inside word 0 and alignment masks of word 1.
`define FES_CMD_MSB 15
`define FES_CMD_LSB 8
`define FES_BLK_MSB 6
`define FES_PHRASE_MASK 16'h0007
`define FES_WORD_MASK 16'h0001
// ==========================================================================
// Backdoor key enable value and byte address of key 0.
`define FES_BACKDOOR_KEY_ENABLE_FIELD_ON 2'h2
`define FES_KEY_BASE 23'h7FFF00
`define FES_KEY_STEP 23'h000002
`define FES_KEY_LAST 2'h3
// ==========================================================================
// Error flag positions and reset values.
`define FES_F_ACC 0
`define FES_F_FPV 1
`define FES_F_MG1 2
`define FES_F_MG0 3
`define FES_FLAGS_RST 4'h0
`define FES_COMMAND_COMPLETE_FLAG_RST 1'b1
`define FES_SEC_RST 1'b1
// ==========================================================================
// Default block codes of the program store and data store.
`define FES_PF_BLK_LO 7'h7C
`define FES_PF_BLK_HI 7'h7F
`define FES_DF_BLK 7'h10
`endif

// ### fes_pkg.sv
/*
   Types of the flash erase and unsecure sequencer.
   Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package fes_pkg;
   // Sequencer states.
   typedef enum logic [3:0] {ST_IDLE, ST_W0, ST_W1, ST_CHECK, ST_PROT, ST_WAIT,
                             ST_KEY, ST_KWAIT, ST_DONE} fes_state_t;
   // Erase scope handed to the array.
   typedef enum logic [1:0] {OP_ALL, OP_BLOCK, OP_SECTOR} fes_op_t;
   // Kind of block named by address bits 22:16.
   typedef enum logic [1:0] {BLK_NONE, BLK_PF, BLK_DF} fes_blk_t;
   // Whole state of the sequencer.
   typedef struct packed {
      fes_state_t st;
      logic [2:0] idx;
      logic [15:0] w0;
      logic [15:0] w1;
      logic [1:0] kk;
      logic kbad;
      logic lock;
      logic sec;
      logic command_complete_flag;
      logic req;
      logic init;
      fes_op_t op;
      logic [22:0] addr;
   } fes_seq_st_t;
endpackage
`default_nettype wire

// ### fes_if.sv
/*
   Carriers between the sequencer and its command word store and flag file.
   Assumes a single clock shared by all users.
*/
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Command word store port.
interface fes_mem_if #(parameter int W = 16, parameter int AW = 3);
   logic wr;
   logic [AW-1:0] waddr;
   logic [W-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [W-1:0] rdata;
   modport ctl (output wr, waddr, wdata, raddr, input rdata);
   modport mem (input wr, waddr, wdata, raddr, output rdata);
endinterface
// ==========================================================================
// Sticky flag port.
interface fes_flag_if #(parameter int N = 4);
   logic [N-1:0] set;
   logic [N-1:0] clr;
   logic [N-1:0] q;
   modport ctl (output set, clr, input q);
   modport flg (input set, clr, output q);
endinterface
`default_nettype wire

// ### fes_cmd_mem.sv
/*
   Command word store: one write port, one read port with registered data.
   Assumes writes and reads come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fes_cmd_mem #(
   parameter int W = 16,
   parameter int AW = 3
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Store port.
   fes_mem_if.mem m
);
   typedef struct packed {
      logic [(1<<AW)-1:0][W-1:0] words;
      logic [W-1:0] rd;
   } fes_mem_st_t;
   fes_mem_st_t s_q;
   fes_mem_st_t s_d;

   // Write the addressed word and fetch the read word into a register.
   always_comb begin
      s_d = s_q;
      if (m.wr) begin
         s_d.words[m.waddr] = m.wdata;
      end
      s_d.rd = s_q.words[m.raddr];
   end

   // Register the store.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign m.rdata = s_q.rd;
endmodule // fes_cmd_mem
`default_nettype wire

// ### fes_flags.sv
/*
   Sticky error flags: a set pulse wins over a clear in the same cycle.
   Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fes_regs.svh"
module fes_flags #(
   parameter int N = 4
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Flag port.
   fes_flag_if.flg f
);
   typedef struct packed {
      logic [N-1:0] q;
   } fes_flg_st_t;
   fes_flg_st_t s_q;
   fes_flg_st_t s_d;

   // Each flag holds until cleared, and a new event beats the clear.
   always_comb begin
      s_d = s_q;
      for (int i = 0; i < N; i++) begin
         s_d.q[i] = f.set[i] | (s_q.q[i] & ~f.clr[i]);
      end
   end

   // Register the flags.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q.q <= N'(`FES_FLAGS_RST);
      end else begin
         s_q <= s_d;
      end
   end

   assign f.q = s_q.q;
endmodule // fes_flags
`default_nettype wire

// ### tb.sv
/*
   Self-checking bench of the flash erase and unsecure sequencer.
   Assumes fes_pkg, fes_regs.svh, fes_if and fes_seq are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fes_regs.svh"
module tb
   import fes_pkg::*;
;
   logic clk_i, rst_i, cmd_wr_i, launch_i, pp, dp, tp, ve, vu, done, kv;
   logic command_complete_flag, acc, fpv, mg1, mg0, sec, lck, ereq, kreq;
   logic [2:0] idx;
   logic [15:0] wd, kd;
   logic [15:0] ktab [4];
   logic [3:0] clr;
   logic [1:0] ke, ecnt;
   logic [22:0] eaddr, kaddr, seen_addr;
   fes_op_t eop, seen_op;
   int n_fail, checks;
   // ==========================================================
   // Device under test.
   fes_seq i_fes_seq (.clk_i(clk_i), .rst_i(rst_i), .cmd_wr_i(cmd_wr_i), .command_word_index_i(idx),
      .command_parameter_words_i(wd), .launch_i(launch_i), .flag_clr_i(clr), .command_complete_flag_o(command_complete_flag),
      .access_error_flag_o(acc), .protection_violation_flag_o(fpv), .verify_error_flag_o(mg1),
      .verify_uncorrectable_flag_o(mg0), .backdoor_key_enable_field_i(ke), .secured_strap_i(1'b1),
      .secured_o(sec), .key_locked_o(lck), .pflash_prot_any_i(pp), .dflash_prot_any_i(dp), .target_prot_i(tp),
      .erase_req_o(ereq), .erase_op_o(eop), .erase_addr_o(eaddr), .erase_done_i(done), .verify_err_i(ve),
      .verify_uncorr_i(vu), .key_rd_req_o(kreq), .key_rd_addr_o(kaddr), .key_rd_valid_i(kv), .key_rd_data_i(kd));
   // Clock of 40 ns.
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // Array and key store stand-ins: erase ends four cycles on, a key word one cycle on.
   always @(posedge clk_i) begin
      if (rst_i) begin
         {done, kv, kd, ecnt} <= '0;
      end else begin
         kv <= kreq & ~kv;
         kd <= ktab[kaddr[2:1]];
         done <= !ereq && (ecnt == 2'h1);
         if (ereq) begin
            ecnt <= 2'h3;
            seen_op <= eop;
            seen_addr <= eaddr;
         end else if (ecnt != 2'h0) begin
            ecnt <= ecnt - 2'h1;
         end
      end
   end
   // ==========================================================
   // Shared tasks.
   task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      chk(n, {3'h0, e}, {3'h0, g});
   endtask
   // Compares an address handed to the erase engine.
   task automatic chk_addr(input string n, input logic [22:0] e, input logic [22:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic do_reset;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic wr(input logic [2:0] i, input logic [15:0] d);
      @(posedge clk_i);
      cmd_wr_i <= 1'b1;
      idx <= i;
      wd <= d;
      @(posedge clk_i);
      cmd_wr_i <= 1'b0;
   endtask
   task automatic env(input logic p, input logic d, input logic t, input logic e, input logic u,
                      input logic [1:0] k);
      @(posedge clk_i);
      {pp, dp, tp, ve, vu, ke} <= {p, d, t, e, u, k};
   endtask
   // Launches with a final index, waits for completion, judges flags and security.
   task automatic run(input logic [2:0] fi, input logic [3:0] ef, input logic es);
      int n;
      @(posedge clk_i);
      idx <= fi;
      launch_i <= 1'b1;
      @(posedge clk_i);
      launch_i <= 1'b0;
      #1;
      chk_bit("busy", 1'b0, command_complete_flag);
      n = 0;
      while (command_complete_flag !== 1'b1 && n < 500) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk_bit("complete", 1'b1, command_complete_flag);
      chk("flags", ef, {mg0, mg1, fpv, acc});
      chk_bit("secured", es, sec);
      @(posedge clk_i);
      clr <= 4'hF;
      @(posedge clk_i);
      clr <= 4'h0;
   endtask
   // Keys are loaded by the bench, never fetched from the key's own block.
   task automatic keys(input logic [15:0] k0);
      wr(3'h0, {`FES_CMD_KEY, 8'h00});
      wr(3'h1, k0);
      for (int i = 1; i < 4; i++) begin
         wr(3'(i + 1), ktab[i]);
      end
   endtask
   // ==========================================================
   // Scenarios.
   task automatic t_reset;
      #1;
      chk("flags", 4'h0, {mg0, mg1, fpv, acc});
      chk({"command_complete_flag"}, 4'h1, {3'h0, command_complete_flag});
      chk_bit("secured", 1'b1, sec);
      chk_bit("locked", 1'b0, lck);
   endtask
   task automatic t_block;
      wr(3'h0, {`FES_CMD_ERASE_BLK, 8'h7C});
      wr(3'h1, 16'h0004);
      run(3'h1, 4'h1, 1'b1);
      wr(3'h0, {`FES_CMD_ERASE_BLK, 8'h10});
      wr(3'h1, 16'h0001);
      run(3'h1, 4'h1, 1'b1);
      wr(3'h0, {`FES_CMD_ERASE_BLK, 8'h20});
      wr(3'h1, 16'h0000);
      run(3'h1, 4'h1, 1'b1);
      wr(3'h0, {`FES_CMD_ERASE_BLK, 8'h7C});
      run(3'h0, 4'h1, 1'b1);
      env(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h2);
      run(3'h1, 4'h2, 1'b1);
      env(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h2);
      run(3'h1, 4'h4, 1'b1);
      chk("op", 4'h1, {2'h0, seen_op});
      chk_addr("addr", 23'h7C0000, seen_addr);
   endtask
   task automatic t_sector;
      env(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
      wr(3'h0, {`FES_CMD_ERASE_SEC, 8'h7C});
      wr(3'h1, 16'h1233);
      run(3'h1, 4'h1, 1'b1);
      wr(3'h1, 16'h1230);
      run(3'h0, 4'h1, 1'b1);
      env(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h2);
      run(3'h1, 4'h2, 1'b1);
      env(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
      run(3'h1, 4'h0, 1'b1);
      chk("op", 4'h2, {2'h0, seen_op});
      chk_addr("addr", 23'h7C1230, seen_addr);
      wr(3'h0, {`FES_CMD_ERASE_SEC, 8'h20});
      run(3'h1, 4'h1, 1'b1);
   endtask
   task automatic t_key;
      keys(ktab[0]);
      env(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1);
      run(3'h4, 4'h1, 1'b1);
      env(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
      run(3'h3, 4'h1, 1'b1);
      run(3'h4, 4'h0, 1'b0);
      do_reset();
      t_reset();
      keys(16'h0000);
      run(3'h4, 4'h1, 1'b1);
      chk_bit("locked", 1'b1, lck);
      keys(ktab[0]);
      run(3'h4, 4'h1, 1'b1);
   endtask
   task automatic t_full;
      wr(3'h0, {`FES_CMD_ERASE_ALL, 8'h00});
      run(3'h1, 4'h1, 1'b1);
      env(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
      run(3'h0, 4'h2, 1'b1);
      wr(3'h0, {`FES_CMD_UNSECURE, 8'h00});
      env(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2);
      run(3'h0, 4'h2, 1'b1);
      run(3'h1, 4'h1, 1'b1);
      env(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 2'h2);
      run(3'h0, 4'hC, 1'b1);
      env(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
      run(3'h0, 4'h0, 1'b0);
      do_reset();
      t_reset();
      wr(3'h0, {`FES_CMD_ERASE_ALL, 8'h00});
      run(3'h0, 4'h0, 1'b0);
      chk("op", 4'h0, {2'h0, seen_op});
   endtask
   // ==========================================================
   // Verdict and run control.
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Main sequence, started with every input at a known value.
   initial begin
      {rst_i, cmd_wr_i, launch_i, pp, dp, tp, ve, vu} = 8'h80;
      {idx, wd, clr, ke} = {3'h0, 16'h0000, 4'h0, 2'h2};
      ktab = '{16'hA51C, 16'h3C96, 16'h0F1E, 16'hD2B4};
      do_reset();
      t_reset();
      t_block();
      t_sector();
      t_key();
      t_full();
      print_verdict();
   end
   // Watchdog well beyond the few hundred cycles the scenarios need.
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      print_verdict();
   end
endmodule // tb
`default_nettype wire
